// ==== ssf_peer.sv ====
// far-side model: clocked serial peer on the data and clock lines
`timescale 1ns/1ps
module ssf_peer
(
   input wire logic sck,
   input wire logic sck_oe,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] out_sh;
   logic [7:0] in_sh;
   int nb = 0;
   int pseed = 32'h0bad1234;
   logic [7:0] sent_q[$];
   logic [7:0] got_q[$];

   initial rxd = 1'b1;

   // ==========================================================
   // drive side: next bit after each falling clock edge, lsb first
   always @(negedge sck)
   begin
      if (sck_oe === 1'b1)
      begin
         if (nb == 0)
         begin
            out_sh = 8'($random(pseed));
            sent_q.push_back(out_sh);
         end
         rxd = out_sh[nb];
      end
   end

   // ==========================================================
   // sample side: rising edge; 40 ns after each frame the data line is inverted
   always @(posedge sck)
   begin
      if (sck_oe === 1'b1)
      begin
         in_sh[nb] = txd;
         nb++;
         if (nb == 8)
         begin
            nb = 0;
            got_q.push_back(in_sh);
            #40 rxd = ~rxd;
         end
      end
   end
endmodule

// ==== ssf_pkg.sv ====
// constants, field layout and carrier types of the synchronous serial fifo port
package ssf_pkg;

   // ==========================================================
   // sizes
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
   localparam logic [3:0] FRAME_BITS = 4'h8;

   // ==========================================================
   // register indices on the plain register port
   localparam logic [3:0] ADR_MODE = 4'h0;
   localparam logic [3:0] ADR_BRR = 4'h1;
   localparam logic [3:0] ADR_CTRL = 4'h2;
   localparam logic [3:0] ADR_TXDATA = 4'h3;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_RXDATA = 4'h5;
   localparam logic [3:0] ADR_FCTL = 4'h6;
   localparam logic [3:0] ADR_COUNT = 4'h7;
   localparam logic [3:0] ADR_PORT = 4'h8;
   localparam logic [3:0] ADR_LINE = 4'h9;

   // ==========================================================
   // field positions
   localparam int FL_ER = 7;
   localparam int FL_TRANSMIT_END_FLAG = 6;
   localparam int FL_TX_FIFO_EMPTY_FLAG = 5;
   localparam int FL_BRK = 4;
   localparam int FL_FER = 3;
   localparam int FL_PER = 2;
   localparam int FL_RDF = 1;
   localparam int FL_DR = 0;
   localparam int CT_TIE = 7;
   localparam int CT_RIE = 6;
   localparam int CT_TE = 5;
   localparam int CT_RE = 4;
   localparam int CT_REIE = 3;
   localparam int CT_CKE1 = 1;
   localparam int MD_CKS = 0;
   localparam int FC_RTRG = 6;
   localparam int FC_TTRG = 4;
   localparam int FC_TFRST = 2;
   localparam int FC_RFRST = 1;
   localparam int FC_LOOP = 0;
   localparam int PT_RTS_IO = 7;
   localparam int PT_RTS_DT = 6;
   localparam int PT_CTS_DT = 4;
   localparam int PT_SCK_IO = 3;
   localparam int PT_SCK_DT = 2;
   localparam int PT_BRK_IO = 1;
   localparam int PT_BRK_DT = 0;

   // ==========================================================
   // reset values and masks
   localparam logic [7:0] BRR_RESET = 8'hff;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h60;
   localparam logic [7:0] FLAG_WRITABLE = 8'hf3;

   // ==========================================================
   // bit rate timing
   localparam int SYS_CLK_KHZ = 100000;
   localparam int MAX_KBPS = 5000;
   localparam logic [15:0] MIN_HALF_CYC = 16'((SYS_CLK_KHZ + 2 * MAX_KBPS - 1) / (2 * MAX_KBPS));

   // ==========================================================
   // types
   typedef enum logic [0:0] {SSF_IDLE, SSF_SHIFT} ssf_phase_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } ssf_bus_req_type;

   typedef struct packed {
      logic sck_i;
      logic rxd;
      logic cts_i;
   } ssf_pins_in_type;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic txd;
      logic rts_o;
      logic rts_oe;
   } ssf_pins_out_type;

   typedef struct packed {
      logic txi;
      logic rxi;
      logic bri;
      logic eri;
      logic xfer_tx_start;
      logic xfer_rx_start;
   } ssf_req_type;

endpackage

// ==== ssf_port.sv ====
// synchronous serial port with 16-byte transmit and receive fifos
// Operation
// - internal clock drives pin, external clock input
// - frames are eight bits, bit zero first
// - internal bit rate capped at top rate
// - receive shifter fills lsb first, then queues
// - receive fifo sixteen bytes, writes ignored
// - empty receive fifo read returns anything
// - byte dropped when full, overrun raised
// - transmitter sends queued bytes back to back
// - transmit fifo ignores writes when full
// - status: high byte zero, flags low
// - flags cleared by zero only after read
// - framing and parity bits are read only
// - divisor byte resets to ff, sets rate
// - mode register picks clock prescaler
// - control enables, interrupt gates, clock select
// - port register drives handshake, clock, break
// - fifo control resets, triggers, loop back
// - count register shows both fifo fills
// - overrun cleared by zero only after read
// - separate requests, fifo ones start transfers
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ssf_port
   import ssf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire ssf_bus_req_type bus_req,
   output logic [15:0] reg_rdata,
   input wire ssf_pins_in_type pin_in,
   output ssf_pins_out_type pin_out,
   output ssf_req_type req_out
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [15:0] mode;
      logic [7:0] brr;
      logic [15:0] ctrl;
      logic [15:0] fctl;
      logic [15:0] port;
      logic [7:0] flags;
      logic [7:0] armed;
      logic overrun_flag;
      logic overrun_flag_armed;
      logic [FIFO_DEPTH-1:0][7:0] txm;
      logic [FIFO_DEPTH-1:0][7:0] rxm;
      logic [PTR_W-1:0] txw;
      logic [PTR_W-1:0] txr;
      logic [PTR_W-1:0] rxw;
      logic [PTR_W-1:0] rxr;
      logic [CNT_W-1:0] txc;
      logic [CNT_W-1:0] rxc;
      ssf_phase_type ph;
      logic [7:0] tsh;
      logic [7:0] rsh;
      logic [3:0] bits;
      logic [15:0] div;
      logic sck;
      logic txd;
      logic [15:0] rdata;
      logic sck_s1;
      logic sck_s2;
      logic sck_d;
      logic rxd_s1;
      logic rxd_s2;
      logic cts_s1;
      logic cts_s2;
   } ssf_state_type;

   ssf_state_type state_reg;
   ssf_state_type state_next;

   // ==========================================================
   // helpers
   // transmit trigger: flag raised at or below this fill
   function automatic logic [CNT_W-1:0] tx_trig(input logic [1:0] code);
      case (code)
         2'h0: tx_trig = 5'h08;
         2'h1: tx_trig = 5'h04;
         2'h2: tx_trig = 5'h02;
         default: tx_trig = 5'h00;
      endcase
   endfunction

   // receive trigger: flag raised at or above this fill
   function automatic logic [CNT_W-1:0] rx_trig(input logic [1:0] code);
      case (code)
         2'h0: rx_trig = 5'h01;
         2'h1: rx_trig = 5'h04;
         2'h2: rx_trig = 5'h08;
         default: rx_trig = 5'h0e;
      endcase
   endfunction

   // half bit time in sys_clk cycles; clamped so the rate never passes the top rate
   function automatic logic [15:0] half_cycles(input logic [7:0] brr, input logic [1:0] cks);
      logic [17:0] h;
      h = ({10'h000, brr} + 18'h00001) << {cks, 1'b1};
      if (h[15:0] < MIN_HALF_CYC)
         h = {2'b00, MIN_HALF_CYC};
      half_cycles = h[15:0];
   endfunction

   logic ext_clk;
   logic tx_en;
   logic rx_en;
   logic rx_bit;
   logic ext_fall;
   logic ext_rise;
   logic fall;
   logic rise;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic overrun_ev;
   logic need_frame;
   logic [7:0] load_byte;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic overrun_flag_clr;
   logic wr_status;
   logic rd_status;

   // ==========================================================
   // next state
   always_comb
   begin
      state_next = state_reg;
      // two-stage synchronisers for everything arriving from pins
      state_next.sck_s1 = pin_in.sck_i;
      state_next.sck_s2 = state_reg.sck_s1;
      state_next.sck_d = state_reg.sck_s2;
      state_next.rxd_s1 = pin_in.rxd;
      state_next.rxd_s2 = state_reg.rxd_s1;
      state_next.cts_s1 = pin_in.cts_i;
      state_next.cts_s2 = state_reg.cts_s1;

      ext_clk = state_reg.ctrl[CT_CKE1];
      tx_en = state_reg.ctrl[CT_TE];
      rx_en = state_reg.ctrl[CT_RE];
      // loop back feeds our own line output into the receiver
      rx_bit = state_reg.fctl[FC_LOOP] ? state_reg.txd : state_reg.rxd_s2;
      ext_fall = state_reg.sck_d & ~state_reg.sck_s2;
      ext_rise = ~state_reg.sck_d & state_reg.sck_s2;
      load_byte = state_reg.txm[state_reg.txr];
      wr_status = bus_req.wr && (bus_req.addr == ADR_STATUS);
      rd_status = bus_req.rd && (bus_req.addr == ADR_STATUS);

      tx_push = bus_req.wr && (bus_req.addr == ADR_TXDATA) && (state_reg.txc != FIFO_FULL_CNT);
      rx_pop = bus_req.rd && (bus_req.addr == ADR_RXDATA) && (state_reg.rxc != '0);
      tx_pop = 1'b0;
      rx_push = 1'b0;
      overrun_ev = 1'b0;
      fall = 1'b0;
      rise = 1'b0;
      // receive-only runs while there is room; with a transmitter it waits for data
      need_frame = tx_en ? (state_reg.txc != '0) : (rx_en && (state_reg.rxc != FIFO_FULL_CNT));

      // frame engine
      case (state_reg.ph)
         SSF_IDLE:
         begin
            state_next.sck = 1'b1;
            if (need_frame)
            begin
               state_next.ph = SSF_SHIFT;
               state_next.bits = '0;
               state_next.div = '0;
               state_next.tsh = 8'hff;
               if (tx_en)
               begin
                  state_next.tsh = load_byte;
                  tx_pop = 1'b1;
               end
            end
         end
         SSF_SHIFT:
         begin
            if (ext_clk)
            begin
               fall = ext_fall;
               rise = ext_rise;
            end
            else if (state_reg.div == half_cycles(state_reg.brr, state_reg.mode[MD_CKS +: 2]) - 16'h0001)
            begin
               state_next.div = '0;
               state_next.sck = ~state_reg.sck;
               fall = state_reg.sck;
               rise = ~state_reg.sck;
            end
            else
               state_next.div = state_reg.div + 16'h0001;
            if (fall)
            begin
               state_next.txd = state_reg.tsh[0];
               state_next.tsh = {1'b1, state_reg.tsh[7:1]};
            end
            if (rise)
            begin
               state_next.rsh = {rx_bit, state_reg.rsh[7:1]};
               state_next.bits = state_reg.bits + 4'h1;
               if (state_reg.bits == FRAME_BITS - 4'h1)
               begin
                  state_next.ph = SSF_IDLE;
                  if (rx_en)
                  begin
                     if (state_reg.rxc == FIFO_FULL_CNT)
                        overrun_ev = 1'b1;
                     else
                        rx_push = 1'b1;
                  end
               end
            end
            // dropping both enables abandons the frame
            if (!(tx_en || rx_en))
            begin
               state_next.ph = SSF_IDLE;
               state_next.sck = 1'b1;
            end
         end
         default:
            state_next.ph = SSF_IDLE;
      endcase

      // fifo storage; the full check above keeps a late write from touching data
      if (tx_push)
      begin
         state_next.txm[state_reg.txw] = bus_req.wdata[7:0];
         state_next.txw = state_reg.txw + 4'h1;
      end
      if (tx_pop)
         state_next.txr = state_reg.txr + 4'h1;
      state_next.txc = state_reg.txc + CNT_W'(tx_push) - CNT_W'(tx_pop);
      if (rx_push)
      begin
         state_next.rxm[state_reg.rxw] = {rx_bit, state_reg.rsh[7:1]};
         state_next.rxw = state_reg.rxw + 4'h1;
      end
      if (rx_pop)
         state_next.rxr = state_reg.rxr + 4'h1;
      state_next.rxc = state_reg.rxc + CNT_W'(rx_push) - CNT_W'(rx_pop);
      if (state_reg.fctl[FC_TFRST])
      begin
         state_next.txw = '0;
         state_next.txr = '0;
         state_next.txc = '0;
      end
      if (state_reg.fctl[FC_RFRST])
      begin
         state_next.rxw = '0;
         state_next.rxr = '0;
         state_next.rxc = '0;
      end

      // plain control registers
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            ADR_MODE: state_next.mode = bus_req.wdata;
            ADR_BRR: state_next.brr = bus_req.wdata[7:0];
            ADR_CTRL: state_next.ctrl = bus_req.wdata;
            ADR_FCTL: state_next.fctl = bus_req.wdata;
            ADR_PORT: state_next.port = bus_req.wdata;
            default: state_next.mode = state_reg.mode;
         endcase
      end

      // status flags: hardware sets win over software clears
      flag_set = '0;
      flag_set[FL_TRANSMIT_END_FLAG] = tx_en && (state_reg.ph == SSF_IDLE) && (state_reg.txc == '0);
      flag_set[FL_TX_FIFO_EMPTY_FLAG] = tx_en && (state_reg.txc <= tx_trig(state_reg.fctl[FC_TTRG +: 2]));
      flag_set[FL_RDF] = rx_en && (state_reg.rxc >= rx_trig(state_reg.fctl[FC_RTRG +: 2]));
      flag_clr = wr_status ? (state_reg.armed & ~bus_req.wdata[7:0] & FLAG_WRITABLE) : 8'h00;
      state_next.flags = (flag_set | (state_reg.flags & ~flag_clr)) & FLAG_WRITABLE;
      state_next.armed = ((state_reg.armed & ~flag_clr) | (rd_status ? state_reg.flags : 8'h00))
         & state_next.flags;
      overrun_flag_clr = bus_req.wr && (bus_req.addr == ADR_LINE) && state_reg.overrun_flag_armed && !bus_req.wdata[0];
      state_next.overrun_flag = overrun_ev || (state_reg.overrun_flag && !overrun_flag_clr);
      state_next.overrun_flag_armed = ((state_reg.overrun_flag_armed && !overrun_flag_clr)
         || (bus_req.rd && (bus_req.addr == ADR_LINE) && state_reg.overrun_flag)) && state_next.overrun_flag;

      // read data stands for exactly the cycle after the strobe
      state_next.rdata = '0;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            ADR_MODE: state_next.rdata = state_reg.mode;
            ADR_BRR: state_next.rdata = {8'h00, state_reg.brr};
            ADR_CTRL: state_next.rdata = state_reg.ctrl;
            ADR_STATUS: state_next.rdata = {8'h00, state_reg.flags};
            ADR_RXDATA: state_next.rdata = {8'h00, state_reg.rxm[state_reg.rxr]};
            ADR_FCTL: state_next.rdata = state_reg.fctl;
            ADR_COUNT: state_next.rdata = {3'h0, state_reg.txc, 3'h0, state_reg.rxc};
            ADR_PORT: state_next.rdata = {state_reg.port[15:5], state_reg.cts_s2, state_reg.port[3:0]};
            ADR_LINE: state_next.rdata = {15'h0000, state_reg.overrun_flag};
            default: state_next.rdata = '0;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= '0;
         state_reg.mode <= REG_RESET;
         state_reg.ctrl <= REG_RESET;
         state_reg.fctl <= REG_RESET;
         state_reg.port <= REG_RESET;
         state_reg.brr <= BRR_RESET;
         state_reg.flags <= FLAGS_RESET;
         state_reg.ph <= SSF_IDLE;
         state_reg.sck <= 1'b1;
         state_reg.txd <= 1'b1;
         state_reg.tsh <= 8'hff;
         state_reg.sck_s1 <= 1'b1;
         state_reg.sck_s2 <= 1'b1;
         state_reg.sck_d <= 1'b1;
      end
      else
         state_reg <= state_next;
   end

   // ==========================================================
   // outputs
   assign reg_rdata = state_reg.rdata;

   // clock pin: driven while the internal clock is selected and an enable is on, else by the port bits when both enables are off
   always_comb
   begin
      pin_out.sck_oe = (!state_reg.ctrl[CT_CKE1] && (state_reg.ctrl[CT_TE] || state_reg.ctrl[CT_RE]))
         || (!(state_reg.ctrl[CT_TE] || state_reg.ctrl[CT_RE]) && state_reg.port[PT_SCK_IO]);
      pin_out.sck_o = (state_reg.ctrl[CT_TE] || state_reg.ctrl[CT_RE]) ? state_reg.sck
         : state_reg.port[PT_SCK_DT];
      // break: the port bits own the line only while the transmitter is off
      pin_out.txd = state_reg.ctrl[CT_TE] ? state_reg.txd
         : (state_reg.port[PT_BRK_IO] ? state_reg.port[PT_BRK_DT] : 1'b1);
      pin_out.rts_o = state_reg.port[PT_RTS_DT];
      pin_out.rts_oe = state_reg.port[PT_RTS_IO];
   end

   // request levels; fifo requests double as transfer starts
   always_comb
   begin
      req_out.txi = state_reg.flags[FL_TX_FIFO_EMPTY_FLAG] && state_reg.ctrl[CT_TIE];
      req_out.rxi = state_reg.flags[FL_RDF] && state_reg.ctrl[CT_RIE];
      req_out.bri = (state_reg.flags[FL_BRK] || state_reg.overrun_flag)
         && (state_reg.ctrl[CT_RIE] || state_reg.ctrl[CT_REIE]);
      req_out.eri = state_reg.flags[FL_ER] && (state_reg.ctrl[CT_RIE] || state_reg.ctrl[CT_REIE]);
      req_out.xfer_tx_start = req_out.txi;
      req_out.xfer_rx_start = req_out.rxi;
   end

   // ==========================================================
   // checks
   default clocking ck @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_brr_reset_value: assert property ($fell(sys_rst) |-> state_reg.brr == BRR_RESET)
      else $error("divisor not ff after reset");
   a_tx_full_drop: assert property ((tx_push == 1'b0 && bus_req.wr && bus_req.addr == ADR_TXDATA
      && !state_reg.fctl[FC_TFRST] && !tx_pop) |=> state_reg.txc == FIFO_FULL_CNT)
      else $error("write to full transmit fifo changed it");
   a_overrun_flag: assert property ((overrun_ev && !rx_pop && !state_reg.fctl[FC_RFRST])
      |=> state_reg.overrun_flag && $stable(state_reg.rxc)) else $error("overrun lost or byte stored");
   a_count_read: assert property ((bus_req.rd && bus_req.addr == ADR_COUNT)
      |=> reg_rdata == {3'h0, $past(state_reg.txc), 3'h0, $past(state_reg.rxc)})
      else $error("count register wrong");
   a_flag_unread_kept: assert property ((wr_status && state_reg.flags[FL_RDF] && !state_reg.armed[FL_RDF])
      |=> state_reg.flags[FL_RDF])
      else $error("unread flag was cleared");
   a_overrun_flag_unread_kept: assert property ((state_reg.overrun_flag && !state_reg.overrun_flag_armed)
      |=> state_reg.overrun_flag)
      else $error("unread overrun was cleared");
   a_frame_length: assert property (rx_push |-> state_reg.bits == FRAME_BITS - 4'h1)
      else $error("frame not eight bits");
   a_load_oldest: assert property (tx_pop |=> state_reg.tsh == $past(load_byte))
      else $error("shifter not loaded with oldest byte");
   a_read_only_bits: assert property (wr_status |=> state_reg.flags[FL_FER:FL_PER] == 2'b00)
      else $error("read only status bits changed");
   a_half_min: assert property ((!ext_clk && state_reg.ph == SSF_SHIFT && $changed(state_reg.sck))
      |=> ($stable(state_reg.sck) || state_reg.ph == SSF_IDLE) [*8])
      else $error("serial clock faster than top rate");
   a_clock_driven: assert property ((state_reg.ph == SSF_SHIFT && !ext_clk && (tx_en || rx_en))
      |-> pin_out.sck_oe && pin_out.sck_o == state_reg.sck)
      else $error("internal clock not on pin");

   c_frame_done: cover property (rx_push);
   c_overrun: cover property (overrun_ev);
   c_tx_back_to_back: cover property (tx_pop ##[1:1000] tx_pop);
   c_flag_cleared: cover property ($fell(state_reg.flags[FL_TX_FIFO_EMPTY_FLAG]));

endmodule

// ==== tb_top.sv ====
// self-checking testbench of the synchronous serial fifo port
`timescale 1ns/1ps
module tb_top
   import ssf_pkg::*;
;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   ssf_bus_req_type bus_req = '0;
   logic [15:0] reg_rdata;
   ssf_pins_in_type pin_in;
   ssf_pins_out_type pin_out;
   ssf_req_type req_out;
   logic cts_in = 1'b0;
   logic peer_rxd;
   logic sck_pin;
   logic ext_sck = 1'b1;
   logic ext_run = 1'b0;
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'h6952c367;
   logic [15:0] v;
   logic [15:0] d;
   logic [7:0] exp_tx[$];

   // ==========================================================
   // clock pin not driven by the port follows the bench's own clock source, which idles high, so undriven reads high
   assign sck_pin = pin_out.sck_oe ? pin_out.sck_o : ext_sck;
   assign pin_in = {sck_pin, peer_rxd, cts_in};
   always #5 sys_clk = ~sys_clk;

   ssf_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .req_out(req_out));
   ssf_peer peer_u (.sck(sck_pin), .sck_oe(pin_out.sck_oe || ext_run), .txd(pin_out.txd), .rxd(peer_rxd));

   // ==========================================================
   // register port cycles and comparison
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] r);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 r = reg_rdata;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] r;
      rd(a, r);
      chk(r, exp);
   endtask

   function automatic logic [15:0] exp_count(input int tx, input int rx);
      return {3'h0, 5'(tx), 3'h0, 5'(rx)};
   endfunction

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // wait for the peer to collect n frames, bounded
   task automatic wait_frames(input int n);
      int k;
      for (k = 0; k < 8000 && peer_u.got_q.size() < n; k++)
         @(posedge sys_clk);
      repeat (5) @(posedge sys_clk);
   endtask

   // ==========================================================
   // watchdog: the whole sequence needs well under 20000 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      end_of_test();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rchk(ADR_BRR, 16'h00ff);
      rchk(ADR_COUNT, exp_count(0, 0));
      wr(ADR_STATUS, 16'hffff);
      wr(ADR_STATUS, 16'h0000);
      rchk(ADR_STATUS, 16'h0060);
      wr(ADR_STATUS, 16'h0000);
      rchk(ADR_STATUS, 16'h0000);
      rchk(4'hf, 16'h0000);
      // random register contents, enables kept off
      repeat (4)
      begin
         v = 16'($random(seed));
         cts_in <= v[15];
         wr(ADR_BRR, v & 16'h00ff);
         rchk(ADR_BRR, v & 16'h00ff);
         wr(ADR_MODE, v & 16'h0003);
         rchk(ADR_MODE, v & 16'h0003);
         wr(ADR_CTRL, v & 16'h00ca);
         rchk(ADR_CTRL, v & 16'h00ca);
         // clock data bit kept high: a driven low pin would be an edge the peer counts as a bit
         d = (v & 16'h00cb) | 16'h0004;
         wr(ADR_PORT, d);
         #1 chk(16'({pin_out.rts_oe, pin_out.rts_o}), 16'(v[7:6]));
         chk(16'(pin_out.txd), 16'(v[1] ? v[0] : 1'b1));
         chk(16'(pin_out.sck_oe), 16'(v[3]));
         rchk(ADR_PORT, d | {11'h0, v[15], 4'h0});
      end
      wr(ADR_PORT, 16'h0000);
      wr(ADR_MODE, 16'h0000);
      wr(ADR_BRR, 16'h0000);
      wr(ADR_CTRL, 16'h0000);
      // fifo reset empties the transmit queue
      wr(ADR_TXDATA, 16'h0011);
      wr(ADR_FCTL, 16'h0004);
      wr(ADR_FCTL, 16'h0000);
      rchk(ADR_COUNT, exp_count(0, 0));
      // seventeen writes, the last one refused
      repeat (17)
      begin
         v = 16'($random(seed)) & 16'h00ff;
         wr(ADR_TXDATA, v);
         if (exp_tx.size() < 16)
            exp_tx.push_back(v[7:0]);
      end
      rchk(ADR_COUNT, exp_count(16, 0));
      wr(ADR_CTRL, 16'h0070);
      #1 chk(16'(pin_out.sck_oe), 16'h0001);
      wait_frames(16);
      chk(16'(pin_out.sck_o), 16'h0001);
      // one more frame while the receive queue is full
      v = 16'h00c3;
      wr(ADR_TXDATA, v);
      exp_tx.push_back(v[7:0]);
      wait_frames(17);
      rchk(ADR_COUNT, exp_count(0, 16));
      rchk(ADR_LINE, 16'h0001);
      chk(16'(req_out), 16'h0019);
      wr(ADR_RXDATA, 16'h00aa);
      rchk(ADR_COUNT, exp_count(0, 16));
      foreach (exp_tx[i])
         chk(16'(peer_u.got_q[i]), 16'(exp_tx[i]));
      for (int i = 0; i < 16; i++)
         rchk(ADR_RXDATA, 16'(peer_u.sent_q[i]));
      rchk(ADR_COUNT, exp_count(0, 0));
      wr(ADR_LINE, 16'h0001);
      rchk(ADR_LINE, 16'h0001);
      wr(ADR_LINE, 16'h0000);
      rchk(ADR_LINE, 16'h0000);
      // external clock from the bench, 16 cycles a bit to stay under the peer limit, looped back
      wr(ADR_FCTL, 16'h0001);
      wr(ADR_CTRL, 16'h0072);
      wr(ADR_TXDATA, 16'h005a);
      #1 chk(16'(pin_out.sck_oe), 16'h0000);
      ext_run = 1'b1;
      repeat (8)
      begin
         repeat (8) @(posedge sys_clk);
         ext_sck <= 1'b0;
         repeat (8) @(posedge sys_clk);
         ext_sck <= 1'b1;
      end
      repeat (8) @(posedge sys_clk);
      ext_run = 1'b0;
      chk(16'(peer_u.got_q[17]), 16'h005a);
      rchk(ADR_RXDATA, 16'h005a);
      rchk(ADR_COUNT, exp_count(0, 0));
      end_of_test();
   end
endmodule
